// [oag_addr_gen.sv]
// Operand address generator top: resolves operand, addresses and PC target.
// Assumes the decoder presents one instruction at a time and waits for done.
`timescale 1ns/1ps
module oag_addr_gen (
  // Clock and reset
  input  wire  logic              ref_clk,
  input  wire  logic              rstn,
  // Decoder request
  input  wire  logic              start,
  input  wire  oag_pkg::oag_op_e  op,
  input  wire  oag_pkg::oag_mode_e mode,
  input  wire  logic              wide,
  input  wire  logic              longOffset,
  input  wire  logic [7:0]        regField,
  input  wire  logic [15:0]       immField,
  input  wire  logic [15:0]       pcNext,
  // Register file
  output logic [7:0]              rfAddr,
  output logic                    rfRead,
  input  wire  logic [7:0]        rfData,
  // Results
  output logic                    done,
  output logic                    illegal,
  output oag_pkg::oag_target_e    target,
  output logic [7:0]              regAddr,
  output logic [15:0]             memAddr,
  output logic [15:0]             pcTarget,
  output logic                    pcLoad,
  output logic [7:0]              operand,
  output logic                    operandValid
);

  oag_rf_if rfi ();

  oag_rf_port rfPort (
    .rfi    (rfi),
    .rfAddr (rfAddr),
    .rfRead (rfRead),
    .rfData (rfData)
  );

  oag_pkg::oag_state_e  state_reg;
  oag_pkg::oag_mode_e   mode_reg;
  oag_pkg::oag_op_e     op_reg;
  logic                 wide_reg;
  logic                 long_reg;
  logic [7:0]           field_reg;
  logic [15:0]          imm_reg;
  logic [15:0]          pc_reg;
  logic [15:0]          pair_reg;

  // Working register number to register-file location
  function automatic logic [7:0] workAddr(input logic [3:0] sel);
    workAddr = oag_pkg::WORK_BASE | {4'h0, sel}; // see RULE3 see RULE20
  endfunction

  // Sign extension of a byte displacement to 16 bits
  function automatic logic [15:0] sext8(input logic [7:0] d);
    sext8 = {{8{d[7]}}, d}; // see RULE8 see RULE16
  endfunction

  // Which modes each instruction class accepts
  function automatic logic modeAllowed(input oag_pkg::oag_op_e o,
                                       input oag_pkg::oag_mode_e m);
    modeAllowed = 1'b0;
    unique case (o)
      oag_pkg::OAG_OP_REGISTER_LOAD:
        modeAllowed = (m != oag_pkg::OAG_ABSOLUTE) &&
                      (m != oag_pkg::OAG_PC_OFFSET);
      oag_pkg::OAG_OP_PROGRAM_MEMORY_LOAD,
      oag_pkg::OAG_OP_EXTERNAL_DATA_LOAD:
        modeAllowed = (m == oag_pkg::OAG_POINTER) ||
                      (m == oag_pkg::OAG_INDEXED) ||
                      (m == oag_pkg::OAG_ABSOLUTE);
      oag_pkg::OAG_OP_ABSOLUTE_JUMP,
      oag_pkg::OAG_OP_CALL:
        modeAllowed = (m == oag_pkg::OAG_ABSOLUTE) ||
                      (m == oag_pkg::OAG_POINTER);
      oag_pkg::OAG_OP_RELATIVE_JUMP:
        modeAllowed = (m == oag_pkg::OAG_PC_OFFSET);
      oag_pkg::OAG_OP_ALU:
        modeAllowed = (m == oag_pkg::OAG_REGISTER) ||
                      (m == oag_pkg::OAG_WORKING) ||
                      (m == oag_pkg::OAG_POINTER) ||
                      (m == oag_pkg::OAG_LITERAL);
      default:
        modeAllowed = 1'b0;
    endcase
  endfunction

  logic isMemOp;
  logic isJumpOp;
  logic accept;
  assign isMemOp  = (op_reg == oag_pkg::OAG_OP_PROGRAM_MEMORY_LOAD) ||
                    (op_reg == oag_pkg::OAG_OP_EXTERNAL_DATA_LOAD);
  assign isJumpOp = (op_reg == oag_pkg::OAG_OP_ABSOLUTE_JUMP) ||
                    (op_reg == oag_pkg::OAG_OP_CALL);
  assign accept   = start && (state_reg == oag_pkg::OAG_IDLE);

  // Register-file read address by state
  always_comb
  begin
    rfi.rd   = 1'b0;
    rfi.addr = 8'h00;
    unique case (state_reg)
      oag_pkg::OAG_READ_PTR:
      begin
        rfi.rd   = 1'b1;
        // Indexed register access reads the offset from a working register
        rfi.addr = (mode_reg == oag_pkg::OAG_INDEXED) ?
                   workAddr(field_reg[3:0]) : field_reg; // see RULE9
      end
      oag_pkg::OAG_READ_PAIR_HI:
      begin
        rfi.rd   = 1'b1;
        rfi.addr = field_reg & oag_pkg::PAIR_EVEN_MASK; // see RULE21
      end
      oag_pkg::OAG_READ_PAIR_LO:
      begin
        rfi.rd   = 1'b1;
        rfi.addr = (field_reg & oag_pkg::PAIR_EVEN_MASK) |
                   oag_pkg::PAIR_LOW_BIT; // see RULE21
      end
      oag_pkg::OAG_READ_OPERAND:
      begin
        rfi.rd   = 1'b1;
        rfi.addr = regAddr;
      end
      default:
      begin
        rfi.rd   = 1'b0;
        rfi.addr = 8'h00;
      end
    endcase
  end

  // Instruction capture
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      mode_reg  <= oag_pkg::OAG_REGISTER;
      op_reg    <= oag_pkg::OAG_OP_ALU;
      wide_reg  <= 1'b0;
      long_reg  <= 1'b0;
      field_reg <= 8'h00;
      imm_reg   <= 16'h0000;
      pc_reg    <= 16'h0000;
    end
    else if (accept)
    begin
      mode_reg  <= mode;
      op_reg    <= op;
      wide_reg  <= wide;
      long_reg  <= longOffset;
      field_reg <= regField;
      imm_reg   <= immField;
      pc_reg    <= pcNext; // see RULE17
    end
  end

  // Sequencer
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      state_reg <= oag_pkg::OAG_IDLE;
    else
    begin
      unique case (state_reg)
        oag_pkg::OAG_IDLE:
          if (accept)
          begin
            if (!modeAllowed(op, mode))
              state_reg <= oag_pkg::OAG_DONE; // see RULE1 see RULE11
            else if (mode == oag_pkg::OAG_POINTER && wide)
              state_reg <= oag_pkg::OAG_READ_PAIR_HI; // see RULE6
            else if (mode == oag_pkg::OAG_INDEXED &&
                     op != oag_pkg::OAG_OP_REGISTER_LOAD)
              state_reg <= oag_pkg::OAG_READ_PAIR_HI; // see RULE10
            else if (mode == oag_pkg::OAG_POINTER ||
                     mode == oag_pkg::OAG_INDEXED)
              state_reg <= oag_pkg::OAG_READ_PTR; // see RULE5 see RULE7
            else if (mode == oag_pkg::OAG_REGISTER ||
                     mode == oag_pkg::OAG_WORKING)
              state_reg <= oag_pkg::OAG_READ_OPERAND; // see RULE2
            else
              state_reg <= oag_pkg::OAG_DONE;
          end
        oag_pkg::OAG_READ_PTR:
          state_reg <= oag_pkg::OAG_READ_OPERAND; // see RULE4
        oag_pkg::OAG_READ_PAIR_HI:
          state_reg <= oag_pkg::OAG_READ_PAIR_LO;
        oag_pkg::OAG_READ_PAIR_LO:
          state_reg <= oag_pkg::OAG_DONE;
        oag_pkg::OAG_READ_OPERAND:
          state_reg <= oag_pkg::OAG_DONE;
        oag_pkg::OAG_DONE:
          state_reg <= oag_pkg::OAG_IDLE;
        // Unused state codes fall back to idle rather than lock up
        default:
          state_reg <= oag_pkg::OAG_IDLE;
      endcase
    end
  end

  // Register pair capture
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pair_reg <= 16'h0000;
    end
    else
    begin
      if (state_reg == oag_pkg::OAG_READ_PAIR_HI)
        pair_reg[15:8] <= rfi.data;
      if (state_reg == oag_pkg::OAG_READ_PAIR_LO)
        pair_reg[7:0] <= rfi.data;
    end
  end

  // Register-file operand address
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      regAddr <= 8'h00;
    else if (accept)
    begin
      if (mode == oag_pkg::OAG_WORKING)
        regAddr <= workAddr(regField[3:0]); // see RULE3
      else
        regAddr <= regField; // see RULE2
    end
    else if (state_reg == oag_pkg::OAG_READ_PTR)
    begin
      if (mode_reg == oag_pkg::OAG_INDEXED)
        regAddr <= 8'(imm_reg[7:0] + rfi.data); // see RULE9 see RULE22
      else
        regAddr <= rfi.data; // see RULE4 see RULE5
    end
  end

  // Memory address and PC target
  logic [15:0] memOffset;
  assign memOffset = long_reg ? imm_reg : sext8(imm_reg[7:0]); // see RULE8

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      memAddr  <= 16'h0000;
      pcTarget <= 16'h0000;
    end
    else if (state_reg == oag_pkg::OAG_READ_PAIR_LO)
    begin
      if (mode_reg == oag_pkg::OAG_INDEXED)
        memAddr <= 16'({pair_reg[15:8], rfi.data} + memOffset); // see RULE22
      else
        memAddr <= {pair_reg[15:8], rfi.data}; // see RULE6
      pcTarget <= {pair_reg[15:8], rfi.data};
    end
    else if (accept && mode == oag_pkg::OAG_ABSOLUTE)
    begin
      memAddr  <= immField; // see RULE13 see RULE15
      pcTarget <= immField; // see RULE14
    end
    else if (accept && mode == oag_pkg::OAG_PC_OFFSET)
      pcTarget <= 16'(pcNext + sext8(immField[7:0])); // see RULE16 see RULE18
  end

  // Operand value
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      operand      <= 8'h00;
      operandValid <= 1'b0;
    end
    else if (accept)
    begin
      operand      <= immField[7:0]; // see RULE19
      operandValid <= (mode == oag_pkg::OAG_LITERAL);
    end
    else if (state_reg == oag_pkg::OAG_READ_OPERAND)
    begin
      operand      <= rfi.data; // see RULE2
      operandValid <= 1'b1;
    end
  end

  // Result classification, held from done until next request
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      illegal <= 1'b0;
      target  <= oag_pkg::OAG_TGT_NONE;
    end
    else if (accept)
    begin
      illegal <= !modeAllowed(op, mode); // see RULE1
      target  <= oag_pkg::OAG_TGT_NONE;
      if (modeAllowed(op, mode))
      begin
        if (op == oag_pkg::OAG_OP_RELATIVE_JUMP ||
            op == oag_pkg::OAG_OP_ABSOLUTE_JUMP ||
            op == oag_pkg::OAG_OP_CALL)
          target <= oag_pkg::OAG_TGT_PC;
        else if (op == oag_pkg::OAG_OP_PROGRAM_MEMORY_LOAD ||
                 op == oag_pkg::OAG_OP_EXTERNAL_DATA_LOAD)
          target <= oag_pkg::OAG_TGT_MEMORY; // see RULE12
        else if (mode != oag_pkg::OAG_LITERAL)
          target <= oag_pkg::OAG_TGT_REGFILE;
      end
    end
  end

  assign done   = (state_reg == oag_pkg::OAG_DONE);
  assign pcLoad = done && !illegal && (target == oag_pkg::OAG_TGT_PC);

  logic isJumpOpIn;
  assign isJumpOpIn = (op == oag_pkg::OAG_OP_ABSOLUTE_JUMP) ||
                      (op == oag_pkg::OAG_OP_CALL);

  // Relative jump target is next PC plus signed displacement
  pc_rel_a: assert property (@(posedge ref_clk) // see RULE16
    disable iff (!rstn)
    accept && mode == oag_pkg::OAG_PC_OFFSET &&
    op == oag_pkg::OAG_OP_RELATIVE_JUMP
    |=> pcLoad && pcTarget == 16'($past(pcNext) +
        {{8{$past(immField[7])}}, $past(immField[7:0])}))
    else $error("relative target wrong");

  // Absolute jump loads the immediate address
  abs_jump_a: assert property (@(posedge ref_clk) // see RULE14
    disable iff (!rstn)
    accept && mode == oag_pkg::OAG_ABSOLUTE && isJumpOpIn
    |=> pcLoad && pcTarget == $past(immField))
    else $error("absolute target wrong");

  // Jump through a register pair loads the pair contents
  pair_jump_a: assert property (@(posedge ref_clk) // see RULE6
    disable iff (!rstn)
    state_reg == oag_pkg::OAG_READ_PAIR_LO && isJumpOp
    |=> pcLoad && pcTarget == {$past(pair_reg[15:8]), $past(rfData)})
    else $error("pair jump target wrong");

  // Working register reads land in c0-cf
  work_space_a: assert property (@(posedge ref_clk) // see RULE20
    disable iff (!rstn)
    state_reg == oag_pkg::OAG_READ_OPERAND &&
    mode_reg == oag_pkg::OAG_WORKING |-> rfAddr[7:4] == 4'hc)
    else $error("working register outside c0-cf");

  // Pair reads go even then odd
  pair_order_a: assert property (@(posedge ref_clk) // see RULE21
    disable iff (!rstn)
    state_reg == oag_pkg::OAG_READ_PAIR_HI
    |-> !rfAddr[0] ##1 rfAddr[0] && rfAddr[7:1] == $past(rfAddr[7:1]))
    else $error("register pair order wrong");

  // Disallowed mode flags illegal and never loads the PC
  mode_subset_a: assert property (@(posedge ref_clk) // see RULE1
    disable iff (!rstn)
    accept && !modeAllowed(op, mode) |=> done && illegal && !pcLoad)
    else $error("illegal mode not flagged");

  // Literal operand equals the field
  literal_op_a: assert property (@(posedge ref_clk) // see RULE19
    disable iff (!rstn)
    accept && mode == oag_pkg::OAG_LITERAL && modeAllowed(op, mode)
    |=> operandValid && operand == $past(immField[7:0]) && done)
    else $error("literal operand wrong");

  // Register-file index sum wraps at 8 bits
  reg_index_a: assert property (@(posedge ref_clk) // see RULE9
    disable iff (!rstn)
    state_reg == oag_pkg::OAG_READ_PTR && mode_reg == oag_pkg::OAG_INDEXED
    |=> regAddr == 8'($past(imm_reg[7:0]) + $past(rfData)))
    else $error("register index sum wrong");

  // Pointer mode reads operand at the address held in the register
  ptr_deref_a: assert property (@(posedge ref_clk) // see RULE4
    disable iff (!rstn)
    state_reg == oag_pkg::OAG_READ_PTR && mode_reg == oag_pkg::OAG_POINTER
    |=> rfRead && rfAddr == $past(rfData))
    else $error("pointer not dereferenced");

  // Memory index uses signed short offset
  mem_index_a: assert property (@(posedge ref_clk) // see RULE8
    disable iff (!rstn)
    state_reg == oag_pkg::OAG_READ_PAIR_LO && mode_reg == oag_pkg::OAG_INDEXED
    && !long_reg
    |=> memAddr == 16'({pair_reg[15:8], $past(rfData)} +
        {{8{imm_reg[7]}}, imm_reg[7:0]}))
    else $error("short offset sum wrong");

  // Memory loads in an allowed mode always resolve to a memory address
  mem_target_a: assert property (@(posedge ref_clk) // see RULE12
    disable iff (!rstn)
    done && !illegal && isMemOp |-> target == oag_pkg::OAG_TGT_MEMORY)
    else $error("memory load target wrong");

endmodule

// [oag_pkg.sv]
// Constants and types shared by the operand address generator.
// Assumes a single core clock domain and no software-visible registers.
//
// Overview of operation
// RULE1: Six addressing modes; each instruction class allows only its subset. The code has seven mode codes in oag_mode_e.
// RULE2: Register mode reads the operand from the named register location.
// RULE3: Working register mode picks one of 16 registers by a 4-bit field.
// RULE4: Pointer mode uses the register contents as the operand address.
// RULE5: Any 8-bit register can point to another register-file location.
// RULE6: Any 16-bit register pair can point into program or external memory.
// RULE7: Base-plus-offset mode adds an offset to a base during execution.
// RULE8: Short memory offset is a signed byte, -128 to +127.
// RULE9: Register-file index adds instruction base to working-register offset.
// RULE10: Memory index adds 8- or 16-bit instruction offset to register pair.
// RULE11: Register-file base-plus-offset is offered only by register_load.
// RULE12: Memory loads support base-plus-offset for program and data memory.
// RULE13: Absolute address mode takes a 16-bit address from the instruction.
// RULE14: Absolute jump and call load the 16-bit target into the PC.
// RULE15: Memory loads may take their address in absolute address mode.
// RULE16: PC-offset mode adds a signed byte displacement to the PC.
// RULE17: The PC already points past the current instruction before adding.
// RULE18: PC-offset addressing serves the relative jump.
// RULE19: Literal mode uses the instruction operand field as the operand.
// RULE20: Working registers map onto register-file locations c0 to cf.
// RULE21: Pairs start even; high byte even register, low byte odd register.
// RULE22: Register sums wrap at 8 bits, memory sums at 16 bits.
package oag_pkg;

  localparam logic [7:0] WORK_BASE = 8'hc0;
  localparam int         WORK_SEL_W = 4;
  localparam logic [7:0] PAIR_EVEN_MASK = 8'hfe;
  localparam logic [7:0] PAIR_LOW_BIT = 8'h01;

  typedef enum logic [2:0] {
    OAG_REGISTER,
    OAG_WORKING,
    OAG_POINTER,
    OAG_INDEXED,
    OAG_ABSOLUTE,
    OAG_PC_OFFSET,
    OAG_LITERAL
  } oag_mode_e;

  typedef enum logic [2:0] {
    OAG_OP_REGISTER_LOAD,
    OAG_OP_PROGRAM_MEMORY_LOAD,
    OAG_OP_EXTERNAL_DATA_LOAD,
    OAG_OP_ABSOLUTE_JUMP,
    OAG_OP_CALL,
    OAG_OP_RELATIVE_JUMP,
    OAG_OP_ALU
  } oag_op_e;

  typedef enum logic [1:0] {
    OAG_TGT_NONE,
    OAG_TGT_REGFILE,
    OAG_TGT_MEMORY,
    OAG_TGT_PC
  } oag_target_e;

  typedef enum logic [2:0] {
    OAG_IDLE,
    OAG_READ_PTR,
    OAG_READ_PAIR_HI,
    OAG_READ_PAIR_LO,
    OAG_READ_OPERAND,
    OAG_DONE
  } oag_state_e;

endpackage

// [oag_rf_if.sv]
// Register-file read port between the sequencer and the address path.
// Assumes reads return data combinationally in the same cycle.
`timescale 1ns/1ps
interface oag_rf_if;
  logic [7:0] addr;
  logic       rd;
  logic [7:0] data;
  modport seq (output addr, output rd, input data);
  modport port (input addr, input rd, output data);
endinterface

// [oag_rf_port.sv]
// Register-file read adaptor: passes the sequencer's address, read strobe and data straight through.
// Assumes the register file answers in the same cycle.
`timescale 1ns/1ps
module oag_rf_port (
  // Sequencer side
  oag_rf_if.port      rfi,
  // Register file side
  output logic [7:0]  rfAddr,
  output logic        rfRead,
  input  wire  [7:0]  rfData
);
  assign rfAddr   = rfi.addr;
  assign rfRead   = rfi.rd;
  assign rfi.data = rfData;
endmodule

// [oag_rf_model.sv]
// Register file model answering the address generator's read port.
// Assumes reads are combinational; the bus is not held between reads.
`timescale 1ns/1ps
module oag_rf_model (
  // Clock
  input  wire logic       ref_clk,
  // Read port
  input  wire logic [7:0] rfAddr,
  input  wire logic       rfRead,
  output logic      [7:0] rfData
);
  logic [7:0] mem [256];
  logic [7:0] lastData;

  initial
  begin
    lastData = 8'h00;
    for (int i = 0; i < 256; i++)
      mem[i] = 8'(i) * 8'h25 + 8'h13;
  end

  // Idle bus shows the inverse of the last byte, so stale reads stand out
  assign rfData = rfRead ? mem[rfAddr] : ~lastData;

  always_ff @(posedge ref_clk)
    if (rfRead)
      lastData <= rfData;
endmodule

// [tb.sv]
// Self-checking bench for the operand address generator.
// Assumes one request at a time, each sent after the previous done.
`timescale 1ns/1ps
module tb;
  logic               ref_clk;
  logic               rstn;
  logic               start;
  oag_pkg::oag_op_e   op;
  oag_pkg::oag_mode_e mode;
  logic               wide;
  logic               longOffset;
  logic [7:0]         regField;
  logic [15:0]        immField;
  logic [15:0]        pcNext;
  logic [7:0]         rfAddr;
  logic               rfRead;
  logic [7:0]         rfData;
  logic               done;
  logic               illegal;
  oag_pkg::oag_target_e target;
  logic [7:0]         regAddr;
  logic [15:0]        memAddr;
  logic [15:0]        pcTarget;
  logic               pcLoad;
  logic [7:0]         operand;
  logic               operandValid;
  int                 error_cnt;
  int                 n_tests;
  int                 cycles;
  logic               loadSeen;

  oag_addr_gen i_dut (
    .ref_clk(ref_clk), .rstn(rstn), .start(start), .op(op), .mode(mode),
    .wide(wide), .longOffset(longOffset), .regField(regField),
    .immField(immField), .pcNext(pcNext), .rfAddr(rfAddr),
    .rfRead(rfRead), .rfData(rfData), .done(done), .illegal(illegal),
    .target(target), .regAddr(regAddr), .memAddr(memAddr),
    .pcTarget(pcTarget), .pcLoad(pcLoad), .operand(operand),
    .operandValid(operandValid)
  );

  oag_rf_model i_rf (
    .ref_clk(ref_clk), .rfAddr(rfAddr), .rfRead(rfRead), .rfData(rfData)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  function automatic logic [7:0] rfv(input logic [7:0] a);
    return a * 8'h25 + 8'h13;
  endfunction

  function automatic logic [15:0] pair(input logic [7:0] a);
    return {rfv(a & 8'hfe), rfv(a | 8'h01)};
  endfunction

  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_tests++;
    if (g !== e)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Start is dropped right after the taking edge; held start would repeat
  task automatic go(input oag_pkg::oag_op_e o, input oag_pkg::oag_mode_e m,
                    input logic w, input logic lo, input logic [7:0] r,
                    input logic [15:0] imm, input logic [15:0] pc);
    int n;
    @(negedge ref_clk);
    op = o;
    mode = m;
    wide = w;
    longOffset = lo;
    regField = r;
    immField = imm;
    pcNext = pc;
    start = 1'b1;
    @(negedge ref_clk);
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 10)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk("done", 16'h0001, {15'h0, done});
    loadSeen = pcLoad;
  endtask

  task automatic t_register();
    go(oag_pkg::OAG_OP_ALU, oag_pkg::OAG_REGISTER, 0, 0, 8'h40, 0, 0);
    chk("regAddr", 16'h0040, regAddr);
    chk("operand", rfv(8'h40), operand);
    chk("target", oag_pkg::OAG_TGT_REGFILE, target);
    chk("illegal", 16'h0000, illegal);
  endtask

  task automatic t_working();
    go(oag_pkg::OAG_OP_ALU, oag_pkg::OAG_WORKING, 0, 0, 8'hfa, 0, 0);
    chk("regAddr", 16'h00ca, regAddr);
    chk("operand", rfv(8'hca), operand);
  endtask

  task automatic t_pointer();
    go(oag_pkg::OAG_OP_ALU, oag_pkg::OAG_POINTER, 0, 0, 8'h31, 0, 0);
    chk("regAddr", rfv(8'h31), regAddr);
    chk("operand", rfv(rfv(8'h31)), operand);
    go(oag_pkg::OAG_OP_PROGRAM_MEMORY_LOAD, oag_pkg::OAG_POINTER,
       1, 0, 8'hc5, 0, 0);
    chk("memAddr", pair(8'hc5), memAddr);
    chk("target", oag_pkg::OAG_TGT_MEMORY, target);
    chk("pcLoad", 16'h0000, loadSeen);
    go(oag_pkg::OAG_OP_ABSOLUTE_JUMP, oag_pkg::OAG_POINTER,
       1, 0, 8'hc8, 0, 0);
    chk("pcTarget", pair(8'hc8), pcTarget);
    chk("pcLoad", 16'h0001, loadSeen);
  endtask

  task automatic t_indexed();
    go(oag_pkg::OAG_OP_REGISTER_LOAD, oag_pkg::OAG_INDEXED,
       0, 0, 8'h07, 16'h00f0, 0);
    chk("regAddr", 8'(8'hf0 + rfv(8'hc7)), regAddr);
    go(oag_pkg::OAG_OP_EXTERNAL_DATA_LOAD, oag_pkg::OAG_INDEXED,
       0, 0, 8'hc2, 16'h0080, 0);
    chk("memAddr", pair(8'hc2) + 16'hff80, memAddr);
    go(oag_pkg::OAG_OP_PROGRAM_MEMORY_LOAD, oag_pkg::OAG_INDEXED,
       0, 1, 8'hc3, 16'h8001, 0);
    chk("memAddr", pair(8'hc3) + 16'h8001, memAddr);
  endtask

  task automatic t_absolute();
    go(oag_pkg::OAG_OP_PROGRAM_MEMORY_LOAD, oag_pkg::OAG_ABSOLUTE,
       0, 0, 0, 16'hbeef, 0);
    chk("memAddr", 16'hbeef, memAddr);
    go(oag_pkg::OAG_OP_EXTERNAL_DATA_LOAD, oag_pkg::OAG_ABSOLUTE,
       0, 0, 0, 16'h1234, 0);
    chk("memAddr", 16'h1234, memAddr);
    go(oag_pkg::OAG_OP_ABSOLUTE_JUMP, oag_pkg::OAG_ABSOLUTE,
       0, 0, 0, 16'hc0de, 0);
    chk("pcTarget", 16'hc0de, pcTarget);
    chk("pcLoad", 16'h0001, loadSeen);
    go(oag_pkg::OAG_OP_CALL, oag_pkg::OAG_ABSOLUTE, 0, 0, 0, 16'h0f0e, 0);
    chk("pcTarget", 16'h0f0e, pcTarget);
    chk("target", oag_pkg::OAG_TGT_PC, target);
  endtask

  task automatic t_relative();
    go(oag_pkg::OAG_OP_RELATIVE_JUMP, oag_pkg::OAG_PC_OFFSET,
       0, 0, 0, 16'h0080, 16'h0010);
    chk("pcTarget", 16'hff90, pcTarget);
    chk("pcLoad", 16'h0001, loadSeen);
    go(oag_pkg::OAG_OP_RELATIVE_JUMP, oag_pkg::OAG_PC_OFFSET,
       0, 0, 0, 16'h007f, 16'hffa0);
    chk("pcTarget", 16'h001f, pcTarget);
  endtask

  task automatic t_literal();
    go(oag_pkg::OAG_OP_ALU, oag_pkg::OAG_LITERAL, 0, 0, 0, 16'h00a5, 0);
    chk("operand", 16'h00a5, operand);
    chk("operandValid", 16'h0001, operandValid);
  endtask

  task automatic t_illegal();
    go(oag_pkg::OAG_OP_RELATIVE_JUMP, oag_pkg::OAG_ABSOLUTE, 0, 0, 0, 0, 0);
    chk("illegal", 16'h0001, illegal);
    go(oag_pkg::OAG_OP_ALU, oag_pkg::OAG_INDEXED, 0, 0, 8'h01, 0, 0);
    chk("illegal", 16'h0001, illegal);
    go(oag_pkg::OAG_OP_REGISTER_LOAD, oag_pkg::OAG_PC_OFFSET, 0, 0, 0, 0, 0);
    chk("illegal", 16'h0001, illegal);
    t_literal();
    chk("illegal", 16'h0000, illegal);
  endtask

  // Bound well above the fewer than one hundred cycles the scenarios need
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles >= 5000)
    begin
      error_cnt++;
      complete_run();
    end
  end

  initial
  begin
    error_cnt = 0;
    n_tests = 0;
    cycles = 0;
    rstn = 1'b0;
    start = 1'b0;
    op = oag_pkg::OAG_OP_ALU;
    mode = oag_pkg::OAG_REGISTER;
    wide = 1'b0;
    longOffset = 1'b0;
    regField = 8'h00;
    immField = 16'h0000;
    pcNext = 16'h0000;
    repeat (20) @(negedge ref_clk);
    chk("done", 16'h0000, done);
    rstn = 1'b1;
    t_register();
    t_working();
    t_pointer();
    t_indexed();
    t_absolute();
    t_relative();
    t_illegal();
    complete_run();
  end
endmodule
